// file: frame_decode_pkg.sv
// shared constants and types for the octal converter write/update decoder
package frame_decode_pkg;
	localparam int FRAME_W = 32;
	localparam int DATA_W = 16;
	localparam int NUM_CH = 8;
	localparam int CH_IDX_W = 3;
	localparam int TOP_BIT = 31;
	localparam int CMD_HI = 27;
	localparam int CMD_LO = 24;
	localparam int ADDR_HI = 23;
	localparam int ADDR_LO = 20;
	localparam int DATA_HI = 19;
	localparam int DATA_LO = 4;
	localparam logic [3:0] CMD_WRITE_UPDATE_ALL = 4'h2;
	localparam logic [3:0] CMD_WRITE_UPDATE_ONE = 4'h3;
	localparam logic [3:0] ADDR_BROADCAST = 4'hF;
	localparam logic [DATA_W-1:0] LATCH_RESET = 16'h0000;

	typedef logic [DATA_W-1:0] sample_t;

	typedef struct packed {
		logic [3:0] command_field;
		logic [3:0] channel_select;
		sample_t data;
	} write_cmd_t;

	typedef enum logic [1:0] {
		ACT_NONE,
		ACT_LOAD_ONE_UPDATE_ALL,
		ACT_LOAD_ONE_UPDATE_ONE,
		ACT_BROADCAST
	} action_t;
endpackage

// file: frame_field_split.sv
// splits a received frame into command, channel select and data fields
`timescale 1ns/1ps
module frame_field_split (
	input wire logic [frame_decode_pkg::FRAME_W-1:0] frame,
	output frame_decode_pkg::write_cmd_t fields,
	output logic frame_ok
);
	import frame_decode_pkg::*;

	// feature bits [3:0] and the don't-care bits [30:28] are dropped here
	always_comb begin
		fields.command_field = frame[CMD_HI:CMD_LO];
		fields.channel_select = frame[ADDR_HI:ADDR_LO];
		fields.data = frame[DATA_HI:DATA_LO];
		frame_ok = ~frame[TOP_BIT];
	end
endmodule // frame_field_split

// file: octal_dac_write_update_decoder.sv
// decoder of write-and-update frames driving eight input and output latches
// Notes on behaviour
// - update-all command to channel H loads H input, then copies all inputs to outputs.
// - update-one command loads chosen input and updates only that channel's output.
// - address with top bit set, not all ones, changes no latch.
// - all-ones address loads every input latch then updates every output.
// - update-all command to channels A to G behaves like channel H.
`timescale 1ns/1ps
module octal_dac_write_update_decoder (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic frame_valid,
	input wire logic [frame_decode_pkg::FRAME_W-1:0] frame,
	output frame_decode_pkg::sample_t input_latch [frame_decode_pkg::NUM_CH],
	output frame_decode_pkg::sample_t output_latch [frame_decode_pkg::NUM_CH],
	output logic software_load_all_trigger,
	output logic invalid_address
);
	import frame_decode_pkg::*;

	write_cmd_t fields;
	logic frame_ok;
	action_t act_d;
	sample_t input_latch_q [NUM_CH];
	sample_t output_latch_q [NUM_CH];
	logic load_all_q;
	logic invalid_q;

	frame_field_split u_split (
		.frame(frame),
		.fields(fields),
		.frame_ok(frame_ok)
	);

	function automatic logic is_write_cmd(input logic [3:0] cmd);
		return (cmd == CMD_WRITE_UPDATE_ALL) || (cmd == CMD_WRITE_UPDATE_ONE);
	endfunction

	always_comb begin
		act_d = ACT_NONE;
		if (frame_valid && frame_ok && is_write_cmd(fields.command_field)) begin
			if (fields.channel_select == ADDR_BROADCAST) begin
				act_d = ACT_BROADCAST;
			end else if (fields.channel_select[CH_IDX_W]) begin
				act_d = ACT_NONE;
			end else if (fields.command_field == CMD_WRITE_UPDATE_ALL) begin
				act_d = ACT_LOAD_ONE_UPDATE_ALL;
			end else begin
				act_d = ACT_LOAD_ONE_UPDATE_ONE;
			end
		end
	end

	// output copy uses the freshly written value so the update reflects this frame
	generate
		for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
			logic hit;
			sample_t in_next;
			assign hit = (fields.channel_select[CH_IDX_W-1:0] == CH_IDX_W'(ch));
			always_comb begin
				in_next = input_latch_q[ch];
				if (act_d == ACT_BROADCAST) begin
					in_next = fields.data;
				end else if ((act_d == ACT_LOAD_ONE_UPDATE_ALL ||
					act_d == ACT_LOAD_ONE_UPDATE_ONE) && hit) begin
					in_next = fields.data;
				end
			end
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					input_latch_q[ch] <= LATCH_RESET;
				end else begin
					input_latch_q[ch] <= in_next;
				end
			end
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					output_latch_q[ch] <= LATCH_RESET;
				end else if (act_d == ACT_BROADCAST || act_d == ACT_LOAD_ONE_UPDATE_ALL) begin
					output_latch_q[ch] <= in_next;
				end else if (act_d == ACT_LOAD_ONE_UPDATE_ONE && hit) begin
					output_latch_q[ch] <= in_next;
				end
			end
			assign input_latch[ch] = input_latch_q[ch];
			assign output_latch[ch] = output_latch_q[ch];
		end
	endgenerate

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			load_all_q <= 1'b0;
		end else begin
			load_all_q <= (act_d == ACT_BROADCAST) || (act_d == ACT_LOAD_ONE_UPDATE_ALL);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			invalid_q <= 1'b0;
		end else begin
			invalid_q <= frame_valid && frame_ok && is_write_cmd(fields.command_field)
				&& fields.channel_select[CH_IDX_W]
				&& (fields.channel_select != ADDR_BROADCAST);
		end
	end

	assign software_load_all_trigger = load_all_q;
	assign invalid_address = invalid_q;
endmodule // octal_dac_write_update_decoder

// file: dec_chk_sva.sv
// assertions on the write/update decoder ports
`timescale 1ns/1ps
module dec_chk import frame_decode_pkg::*; (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic frame_valid,
	input wire logic [FRAME_W-1:0] frame,
	input sample_t input_latch [NUM_CH],
	input sample_t output_latch [NUM_CH],
	input wire logic software_load_all_trigger,
	input wire logic invalid_address
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire wr = frame_valid & !frame[31] & frame[27:25] == 3'h1;
	wire [3:0] ad = frame[23:20];
	wire bad = wr & ad[3] & ad != 4'hF;
	sequence s_all; wr & !frame[24] & !bad; endsequence
	sequence s_upd; software_load_all_trigger & output_latch[3] == input_latch[3]; endsequence
	property p_inv; bad |=> invalid_address & !software_load_all_trigger; endproperty
	a_inv: assert property (p_inv) else $error("bad address not flagged");
	property p_all; s_all |=> s_upd; endproperty
	a_all: assert property (p_all) else $error("update-all missed");
	property p_h; wr & !frame[24] & ad == 4'h7 |=> input_latch[7] == $past(frame[19:4]); endproperty
	a_h: assert property (p_h) else $error("channel H load wrong");
	property p_one; wr & frame[24] & !ad[3] |=> !software_load_all_trigger; endproperty
	a_one: assert property (p_one) else $error("update-one pulsed trigger");
	property p_bc;
		wr & ad == 4'hF |=> s_upd and (input_latch[0] == $past(frame[19:4]));
	endproperty
	a_bc: assert property (p_bc) else $error("broadcast wrong");
	property p_ign; frame_valid & frame[31] |=> !software_load_all_trigger & !invalid_address;
	endproperty
	a_ign: assert property (p_ign) else $error("frame with top bit acted on");
endmodule // dec_chk
bind octal_dac_write_update_decoder dec_chk chk_u (.mclk, .rst_n, .frame_valid, .frame,
	.input_latch, .output_latch, .software_load_all_trigger, .invalid_address);

// file: host_src.sv
// host side: frames one per cycle, bus inverted when idle
`timescale 1ns/1ps
module host_src (
	input wire logic mclk,
	output logic frame_valid,
	output logic [31:0] frame
);
	initial frame_valid = 1'b0;
	initial frame = 32'h0;
	task automatic put(input logic [31:0] f);
		frame_valid <= 1'b1;
		frame <= f;
		@(negedge mclk);
	endtask
	task automatic idle();
		frame_valid <= 1'b0;
		frame <= ~frame;
	endtask
endmodule // host_src

// file: tb.sv
// self-checking bench for the write/update decoder
`timescale 1ns/1ps
module tb;
	import frame_decode_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	wire frame_valid;
	wire [31:0] frame;
	sample_t il [NUM_CH];
	sample_t ol [NUM_CH];
	logic trig, inv;
	int miscompares = 0;
	int check_count = 0;
	sample_t mi [8] = '{default: 16'h0};
	sample_t mo [8] = '{default: 16'h0};
	logic et, ei;
	always #50 mclk = ~mclk;
	host_src host_u (.mclk, .frame_valid, .frame);
	octal_dac_write_update_decoder dut_u (.mclk, .rst_n, .frame_valid, .frame, .input_latch(il),
		.output_latch(ol), .software_load_all_trigger(trig), .invalid_address(inv));
	task automatic chk_lat(input string n, input logic [15:0] e, input logic [15:0] s);
		check_count++;
		if (e !== s) begin
			miscompares++;
			$display("unexpected %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic chk_pls(input string n, input logic e, input logic s);
		check_count++;
		if (e !== s) begin
			miscompares++;
			$display("unexpected %s exp %b got %b", n, e, s);
		end
	endtask
	task automatic send(input logic [31:0] f);
		logic [3:0] a;
		a = f[23:20];
		et = 1'b0;
		ei = 1'b0;
		if (!f[31] && f[27:25] == 3'h1) begin
			ei = a[3] && a != 4'hF;
			et = !ei && (!f[24] || a == 4'hF);
			for (int k = 0; k < 8; k++) begin
				if (!ei && (a == 4'hF || a == k)) mi[k] = f[19:4];
				if (et || (!ei && a == k)) mo[k] = mi[k];
			end
		end
		host_u.put(f);
		for (int k = 0; k < 8; k++) begin
			chk_lat("input latch", mi[k], il[k]);
			chk_lat("output latch", mo[k], ol[k]);
		end
		chk_pls("trigger", et, trig);
		chk_pls("invalid", ei, inv);
	endtask
	task automatic wrap_up();
		$display("compares %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		void'($urandom(32'haaf8));
		repeat (8) @(negedge mclk);
		rst_n <= 1'b1;
		for (int c = 1; c < 5; c++)
			for (int a = 0; a < 16; a++) send({4'h0, c[3:0], a[3:0], 20'($urandom)});
		send({8'h82, 4'h7, 20'($urandom)});
		send({8'hFD, 4'h0, 20'($urandom)});
		// inverse of the last frame is a broadcast write, offered with valid low
		host_u.idle();
		@(negedge mclk);
		for (int k = 0; k < 8; k++) begin
			chk_lat("idle input latch", mi[k], il[k]);
			chk_lat("idle output latch", mo[k], ol[k]);
		end
		chk_pls("idle trigger", 1'b0, trig);
		chk_pls("idle invalid", 1'b0, inv);
		wrap_up();
	end
	initial begin
		#200000;
		miscompares++;
		wrap_up();
	end
endmodule // tb
